// ---- logic/swpm_pkg.sv ----
/*
  Shared constants and types for the switch power manager: register offsets,
  field positions, reset values, mode encoding and timing counts.
  Assumes a 25 MHz core clock and a 16-bit register port.
*/
package swpm_pkg;

  localparam int AW = 5;
  localparam int DW = 16;

  // register offsets
  localparam logic [AW-1:0] REG_PWR_CTRL = 5'h00;
  localparam logic [AW-1:0] REG_PORT_PD = 5'h01;
  localparam logic [AW-1:0] REG_EEE_EN = 5'h02;
  localparam logic [AW-1:0] REG_WAKE_CTRL = 5'h03;
  localparam logic [AW-1:0] REG_WAKE_STAT = 5'h04;
  localparam logic [AW-1:0] REG_NOEN_TMO = 5'h05;
  localparam logic [AW-1:0] REG_EN_WAKE_TM = 5'h06;
  localparam logic [AW-1:0] REG_STATUS = 5'h07;
  localparam logic [AW-1:0] REG_MAC_HI = 5'h08;
  localparam logic [AW-1:0] REG_MAC_MID = 5'h09;
  localparam logic [AW-1:0] REG_MAC_LO = 5'h0a;
  localparam logic [AW-1:0] REG_STRAP = 5'h0b;

  // field positions
  localparam int MODE_LSB = 3;
  localparam int MODE_MSB = 4;
  localparam int WAKE_ENERGY = 0;
  localparam int WAKE_LINK = 1;
  localparam int WAKE_MAGIC = 2;

  // global power mode field
  typedef enum logic [1:0] {
    PM_NORMAL = 2'h0,
    PM_ENERGY = 2'h1,
    PM_SOFT_PD = 2'h2,
    PM_RSVD = 2'h3
  } swpm_mode_e;

  typedef enum logic [0:0] {ED_NORMAL_PWR, ED_LOW_PWR} swpm_ed_e;

  typedef struct packed {
    logic int_en;
    logic pme_en;
    logic magic_en;
    logic link_en;
    logic energy_en;
  } swpm_wake_s;

  // reset values
  localparam logic [4:0] PORT_PD_RST = 5'h00;
  localparam logic [3:0] EEE_EN_RST = 4'h0;
  localparam swpm_wake_s WAKE_CTRL_RST = 5'h00;
  localparam logic [DW-1:0] NOEN_TMO_RST = 16'h03e8;
  localparam logic [DW-1:0] EN_WAKE_TM_RST = 16'h000a;
  localparam logic [47:0] MAC_ADDR_RST = 48'h000000000000;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int ED_PERSIST_NS = 100;
  localparam int ED_PERSIST_CYC = (ED_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_PERIOD_NS;
  localparam int RFR_PERIOD_US = 20000;
  localparam int RFR_PERIOD_CYC = RFR_PERIOD_US * US_CYC;
  localparam int RFR_LEN_US = 200;
  localparam int RFR_LEN_CYC = RFR_LEN_US * US_CYC;
  localparam int LP_INTERVAL_US = 16000;
  localparam int LP_INTERVAL_CYC = LP_INTERVAL_US * US_CYC;
  localparam int RXCLK_STOP_CYC = 9;

  // wake packet
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [2:0] SYNC_LAST = 3'h5;
  localparam logic [2:0] MAC_BYTE_LAST = 3'h5;
  localparam logic [3:0] MAC_REP_LAST = 4'hf;

endpackage : swpm_pkg

// ---- logic/swpm_top.sv ----
/*
  Global and per-port power manager of a multi-port switch: power modes,
  energy-detect states, EEE low-power idle, wake detection and host signalling.
  Assumes all inputs synchronous to SYS_CLK and a single-cycle register port.
*/
`timescale 1ns/1ps
`default_nettype none
module swpm_top
  import swpm_pkg::*;
#(
  parameter int NPHY = 4,
  parameter int REFRESH_PERIOD_CYC = RFR_PERIOD_CYC,
  parameter int REFRESH_LEN_CYC = RFR_LEN_CYC,
  parameter int LINK_PULSE_CYC = LP_INTERVAL_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [AW-1:0] REG_ADDR,
  input wire logic [DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DW-1:0] REG_RDATA,
  input wire logic [7:0] STRAP_IN,
  input wire logic [NPHY-1:0] ENERGY,
  input wire logic [NPHY-1:0] LINK_UP,
  input wire logic [NPHY-1:0] LINK_EEE_OK,
  input wire logic [NPHY-1:0] MAC_TX_LPI_REQ,
  input wire logic [NPHY-1:0] RX_PCODE,
  input wire logic [NPHY-1:0] RX_OTHER,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_BYTE_VALID,
  input wire logic RX_FRAME_START,
  output logic PLL_EN,
  output logic MAC_EN,
  output logic HOST_IF_EN,
  output logic PHY_EN,
  output logic RX_ENERGY_DET_EN,
  output logic LINK_PULSE,
  output logic [NPHY:0] PORT_POWER_DOWN,
  output logic [NPHY-1:0] TX_LPI,
  output logic [NPHY-1:0] TX_REFRESH,
  output logic [NPHY-1:0] MAC_RX_LPI,
  output logic [NPHY-1:0] RX_CLK_STOP,
  output logic [7:0] STRAP_CFG,
  output logic POWER_EVENT_N,
  output logic INTERRUPT_REQUEST_N
);

  localparam int RFW = $clog2(REFRESH_PERIOD_CYC + REFRESH_LEN_CYC + 1);
  localparam int LPW = $clog2(LINK_PULSE_CYC + 1);
  localparam int USW = $clog2(US_CYC + 1);

  function automatic logic wr_hit(input logic wr, input logic [AW-1:0] a,
                                  input logic [AW-1:0] off);
    return wr && (a == off);
  endfunction : wr_hit

  function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [2:0] idx);
    return mac[8'(47 - 8 * int'(idx)) -: 8];
  endfunction : mac_byte

  ////////////////////////////////////////////////////////////////////////////
  // registers

  swpm_mode_e mode;
  logic [NPHY:0] port_pd;
  logic [NPHY-1:0] eee_en;
  swpm_wake_s wake_ctrl;
  logic [DW-1:0] noen_tmo;
  logic [DW-1:0] en_wake_tm;
  logic [47:0] mac_addr;
  logic [2:0] wake_stat;
  logic [7:0] strap_cfg;
  logic strap_pending;
  swpm_ed_e ed_state;
  logic spd_exit;
  logic [1:0] wr_mode;

  assign wr_mode = REG_WDATA[MODE_MSB:MODE_LSB];
  assign spd_exit = wr_hit(REG_WR, REG_ADDR, REG_PWR_CTRL) && mode == PM_SOFT_PD
                    && wr_mode != PM_SOFT_PD && wr_mode != PM_RSVD;

  // the reserved code is refused so exactly one mode always applies
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      mode <= PM_NORMAL;
    else if (spd_exit)
      mode <= PM_NORMAL;
    else if (wr_hit(REG_WR, REG_ADDR, REG_PWR_CTRL) && wr_mode != PM_RSVD)
      mode <= swpm_mode_e'(wr_mode);
  end

  // software-owned settings fall back to defaults on soft power-down exit
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      port_pd <= PORT_PD_RST;
      eee_en <= EEE_EN_RST;
      wake_ctrl <= WAKE_CTRL_RST;
      noen_tmo <= NOEN_TMO_RST;
      en_wake_tm <= EN_WAKE_TM_RST;
      mac_addr <= MAC_ADDR_RST;
    end
    else if (spd_exit)
    begin
      port_pd <= PORT_PD_RST;
      eee_en <= EEE_EN_RST;
      wake_ctrl <= WAKE_CTRL_RST;
      noen_tmo <= NOEN_TMO_RST;
      en_wake_tm <= EN_WAKE_TM_RST;
      mac_addr <= MAC_ADDR_RST;
    end
    else if (REG_WR)
    begin
      unique case (REG_ADDR)
        REG_PORT_PD: port_pd <= REG_WDATA[NPHY:0];
        REG_EEE_EN: eee_en <= REG_WDATA[NPHY-1:0];
        REG_WAKE_CTRL: wake_ctrl <= REG_WDATA[4:0];
        REG_NOEN_TMO: noen_tmo <= REG_WDATA;
        REG_EN_WAKE_TM: en_wake_tm <= REG_WDATA;
        REG_MAC_HI: mac_addr[47:32] <= REG_WDATA;
        REG_MAC_MID: mac_addr[31:16] <= REG_WDATA;
        REG_MAC_LO: mac_addr[15:0] <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // straps are caught one edge after reset release or soft power-down exit
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      strap_pending <= 1'b1;
      strap_cfg <= 8'h00;
    end
    else
    begin
      if (strap_pending)
        strap_cfg <= STRAP_IN;
      strap_pending <= spd_exit;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      REG_RDATA <= 16'h0000;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        REG_PWR_CTRL: REG_RDATA <= {11'h000, mode, 3'h0};
        REG_PORT_PD: REG_RDATA <= {{(DW-NPHY-1){1'b0}}, port_pd};
        REG_EEE_EN: REG_RDATA <= {{(DW-NPHY){1'b0}}, eee_en};
        REG_WAKE_CTRL: REG_RDATA <= {11'h000, wake_ctrl};
        REG_WAKE_STAT: REG_RDATA <= {13'h0000, wake_stat};
        REG_NOEN_TMO: REG_RDATA <= noen_tmo;
        REG_EN_WAKE_TM: REG_RDATA <= en_wake_tm;
        REG_STATUS: REG_RDATA <= {MAC_RX_LPI[3:0], TX_LPI[3:0], 5'h00, ed_state, mode};
        REG_MAC_HI: REG_RDATA <= mac_addr[47:32];
        REG_MAC_MID: REG_RDATA <= mac_addr[31:16];
        REG_MAC_LO: REG_RDATA <= mac_addr[15:0];
        REG_STRAP: REG_RDATA <= {8'h00, strap_cfg};
        default: REG_RDATA <= 16'h0000;
      endcase
    end
    else
      REG_RDATA <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // energy-detect power-down

  logic any_energy;
  logic [USW-1:0] us_pre;
  logic us_tick;
  logic [DW-1:0] noen_cnt;
  logic [1:0] en_run;
  logic [LPW-1:0] lp_cnt;
  logic pwr_full;
  logic spd;

  assign any_energy = |(ENERGY & ~port_pd[NPHY-1:0]);
  assign us_tick = us_pre == USW'(US_CYC - 1);
  assign spd = mode == PM_SOFT_PD;
  assign pwr_full = mode == PM_NORMAL || (mode == PM_ENERGY && ed_state == ED_NORMAL_PWR);

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      us_pre <= '0;
    else if (us_tick)
      us_pre <= '0;
    else
      us_pre <= us_pre + 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      ed_state <= ED_NORMAL_PWR;
    else if (mode != PM_ENERGY)
      ed_state <= ED_NORMAL_PWR;
    else
    begin
      unique case (ed_state)
        ED_NORMAL_PWR:
          if (us_tick && !any_energy && noen_cnt >= noen_tmo)
            ed_state <= ED_LOW_PWR;
        ED_LOW_PWR:
          if (any_energy && en_run == 2'(ED_PERSIST_CYC - 1))
            ed_state <= ED_NORMAL_PWR;
      endcase
    end
  end

  // microseconds without energy, saturating
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      noen_cnt <= '0;
    else if (any_energy || mode != PM_ENERGY || ed_state == ED_LOW_PWR)
      noen_cnt <= '0;
    else if (us_tick && noen_cnt != 16'hffff)
      noen_cnt <= noen_cnt + 1'b1;
  end

  // consecutive energy cycles in low power; a glitch restarts the count
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      en_run <= '0;
    else if (!any_energy || ed_state != ED_LOW_PWR)
      en_run <= '0;
    else if (en_run != 2'h3)
      en_run <= en_run + 1'b1;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      lp_cnt <= '0;
      LINK_PULSE <= 1'b0;
    end
    else if (ed_state != ED_LOW_PWR)
    begin
      lp_cnt <= '0;
      LINK_PULSE <= 1'b0;
    end
    else
    begin
      LINK_PULSE <= lp_cnt == LPW'(LINK_PULSE_CYC - 1);
      lp_cnt <= (lp_cnt == LPW'(LINK_PULSE_CYC - 1)) ? '0 : lp_cnt + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PLL_EN <= 1'b1;
      MAC_EN <= 1'b1;
      HOST_IF_EN <= 1'b1;
      PHY_EN <= 1'b1;
      RX_ENERGY_DET_EN <= 1'b0;
      PORT_POWER_DOWN <= '0;
    end
    else
    begin
      PLL_EN <= pwr_full;
      MAC_EN <= pwr_full;
      HOST_IF_EN <= pwr_full;
      PHY_EN <= pwr_full;
      RX_ENERGY_DET_EN <= mode == PM_ENERGY;
      PORT_POWER_DOWN <= port_pd | {(NPHY+1){spd}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // energy efficient ethernet, one slice per PHY port

  logic [NPHY-1:0] eee_active;
  logic [RFW-1:0] rf_cnt [NPHY];
  logic [3:0] rx_cnt [NPHY];
  logic [NPHY-1:0] tx_lpi;
  logic [NPHY-1:0] rx_lpi;

  // needs local enable and a negotiated partner
  assign eee_active = eee_en & LINK_EEE_OK & ~port_pd[NPHY-1:0] & {NPHY{pwr_full}};

  for (genvar i = 0; i < NPHY; i++)
  begin : g_eee
    // transmit idle only follows the MAC; dropping the request wakes at once
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
      if (!RESETN)
        tx_lpi[i] <= 1'b0;
      else
        tx_lpi[i] <= eee_active[i] && MAC_TX_LPI_REQ[i];
    end

    // quiet period then refresh burst, repeating while idle
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
      if (!RESETN)
        rf_cnt[i] <= '0;
      else if (!tx_lpi[i])
        rf_cnt[i] <= '0;
      else if (rf_cnt[i] == RFW'(REFRESH_PERIOD_CYC + REFRESH_LEN_CYC - 1))
        rf_cnt[i] <= '0;
      else
        rf_cnt[i] <= rf_cnt[i] + 1'b1;
    end

    // a non-refresh pattern takes priority so traffic is never held off
    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
      if (!RESETN)
        rx_lpi[i] <= 1'b0;
      else if (!eee_active[i] || RX_OTHER[i])
        rx_lpi[i] <= 1'b0;
      else if (RX_PCODE[i])
        rx_lpi[i] <= 1'b1;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
      if (!RESETN)
        rx_cnt[i] <= '0;
      else if (!rx_lpi[i])
        rx_cnt[i] <= '0;
      else if (rx_cnt[i] != 4'(RXCLK_STOP_CYC))
        rx_cnt[i] <= rx_cnt[i] + 1'b1;
    end

    assign TX_LPI[i] = tx_lpi[i];
    assign TX_REFRESH[i] = tx_lpi[i] && rf_cnt[i] >= RFW'(REFRESH_PERIOD_CYC);
    assign MAC_RX_LPI[i] = rx_lpi[i];
    assign RX_CLK_STOP[i] = rx_lpi[i] && rx_cnt[i] == 4'(RXCLK_STOP_CYC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake events

  logic [NPHY-1:0] link_q;
  logic [DW-1:0] en_wake_cnt;
  logic en_wake_done;
  logic energy_ev;
  logic [2:0] ff_cnt;
  logic in_addr;
  logic [2:0] byte_i;
  logic [3:0] rep;
  logic magic_hit;
  logic [2:0] wake_set;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      link_q <= '0;
    else
      link_q <= LINK_UP;
  end

  // one event per energy episode longer than the wake time
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      en_wake_cnt <= '0;
      en_wake_done <= 1'b0;
    end
    else if (!any_energy)
    begin
      en_wake_cnt <= '0;
      en_wake_done <= 1'b0;
    end
    else if (us_tick && !en_wake_done)
    begin
      en_wake_cnt <= en_wake_cnt + 1'b1;
      en_wake_done <= en_wake_cnt >= en_wake_tm;
    end
  end

  assign energy_ev = us_tick && any_energy && !en_wake_done && en_wake_cnt >= en_wake_tm;

  // scanner: a run of sync bytes, then sixteen unbroken copies of the address
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ff_cnt <= '0;
      in_addr <= 1'b0;
      byte_i <= '0;
      rep <= '0;
      magic_hit <= 1'b0;
    end
    else
    begin
      magic_hit <= 1'b0;
      if (RX_FRAME_START)
      begin
        ff_cnt <= '0;
        in_addr <= 1'b0;
      end
      else if (RX_BYTE_VALID && !in_addr)
      begin
        if (RX_BYTE != SYNC_BYTE)
          ff_cnt <= '0;
        else if (ff_cnt == SYNC_LAST)
        begin
          in_addr <= 1'b1;
          byte_i <= '0;
          rep <= '0;
        end
        else
          ff_cnt <= ff_cnt + 1'b1;
      end
      else if (RX_BYTE_VALID)
      begin
        if (RX_BYTE == mac_byte(mac_addr, byte_i))
        begin
          byte_i <= (byte_i == MAC_BYTE_LAST) ? '0 : byte_i + 1'b1;
          if (byte_i == MAC_BYTE_LAST)
            rep <= rep + 1'b1;
          if (byte_i == MAC_BYTE_LAST && rep == MAC_REP_LAST)
          begin
            magic_hit <= 1'b1;
            in_addr <= 1'b0;
            ff_cnt <= '0;
          end
        end
        else if (!(RX_BYTE == SYNC_BYTE && byte_i == '0 && rep == '0))
        begin
          in_addr <= 1'b0;
          ff_cnt <= (RX_BYTE == SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end
    end
  end

  assign wake_set = {magic_hit && wake_ctrl.magic_en,
                     (|(LINK_UP & ~link_q)) && wake_ctrl.link_en,
                     energy_ev && wake_ctrl.energy_en} & {3{!spd}};

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      wake_stat <= '0;
    else if (spd_exit)
      wake_stat <= '0;
    else if (wr_hit(REG_WR, REG_ADDR, REG_WAKE_STAT))
      wake_stat <= (wake_stat & ~REG_WDATA[2:0]) | wake_set;
    else
      wake_stat <= wake_stat | wake_set;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      POWER_EVENT_N <= 1'b1;
      INTERRUPT_REQUEST_N <= 1'b1;
    end
    else
    begin
      POWER_EVENT_N <= !(wake_ctrl.pme_en && |wake_stat);
      INTERRUPT_REQUEST_N <= !(wake_ctrl.int_en && |wake_stat);
    end
  end

  assign STRAP_CFG = strap_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_mode_legal;
    @(posedge SYS_CLK) disable iff (!RESETN) mode != PM_RSVD;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");

  property p_spd_restore;
    @(posedge SYS_CLK) disable iff (!RESETN)
      spd_exit |=> mode == PM_NORMAL && eee_en == '0 && wake_ctrl == '0 ##1
                   strap_cfg == $past(STRAP_IN);
  endproperty
  a_spd_restore: assert property (p_spd_restore) else $error("soft pd exit");

  property p_ed_entry;
    @(posedge SYS_CLK) disable iff (!RESETN)
      $rose(ed_state == ED_LOW_PWR) |-> $past(noen_cnt) >= $past(noen_tmo)
                                        && $past(mode) == PM_ENERGY;
  endproperty
  a_ed_entry: assert property (p_ed_entry) else $error("early low power");

  property p_ed_wake;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (ed_state == ED_LOW_PWR && any_energy && !REG_WR)[*3] |=> ed_state == ED_NORMAL_PWR;
  endproperty
  a_ed_wake: assert property (p_ed_wake) else $error("no wake on energy");

  property p_ed_stay;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ed_state == ED_LOW_PWR && !any_energy && !REG_WR |=> ed_state == ED_LOW_PWR;
  endproperty
  a_ed_stay: assert property (p_ed_stay) else $error("left low power");

  property p_low_off;
    @(posedge SYS_CLK) disable iff (!RESETN)
      ed_state == ED_LOW_PWR |=> !PLL_EN && !MAC_EN && !HOST_IF_EN && RX_ENERGY_DET_EN;
  endproperty
  a_low_off: assert property (p_low_off) else $error("circuits on in low power");

  property p_tx_lpi;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (eee_active[0] && MAC_TX_LPI_REQ[0] |=> TX_LPI[0])
      and (!MAC_TX_LPI_REQ[0] |=> !TX_LPI[0] && !TX_REFRESH[0]);
  endproperty
  a_tx_lpi: assert property (p_tx_lpi) else $error("tx idle mismatch");

  property p_rx_stop;
    @(posedge SYS_CLK) disable iff (!RESETN)
      $rose(RX_CLK_STOP[0]) |-> $past(rx_lpi[0], 9) && $past(rx_lpi[0], 1);
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx clock stopped early");

  property p_eee_off;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !eee_en[0] |=> !TX_LPI[0] && !MAC_RX_LPI[0];
  endproperty
  a_eee_off: assert property (p_eee_off) else $error("idle without enable");

  property p_magic_set;
    @(posedge SYS_CLK) disable iff (!RESETN)
      magic_hit && wake_ctrl.magic_en && !spd && !spd_exit |=> wake_stat[WAKE_MAGIC] ##1
      (!POWER_EVENT_N || !wake_ctrl.pme_en || !wake_stat[WAKE_MAGIC]);
  endproperty
  a_magic_set: assert property (p_magic_set) else $error("wake not reported");

  c_ed_cycle: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
    ed_state == ED_LOW_PWR ##[1:1000] ed_state == ED_NORMAL_PWR);
  c_refresh: cover property (@(posedge SYS_CLK) disable iff (!RESETN) $rose(TX_REFRESH[0]));
  c_magic: cover property (@(posedge SYS_CLK) disable iff (!RESETN) magic_hit);
  c_spd_exit: cover property (@(posedge SYS_CLK) disable iff (!RESETN) spd_exit);

endmodule : swpm_top
`default_nettype wire

// ---- dv/swpm_lp.sv ----
/* link partner model: cable energy, link state, EEE ability, refresh and
   other patterns; assumes per-port commands from the bench, core clock */
`timescale 1ns/1ps
`default_nettype none
module swpm_lp
(
  input wire logic clk,
  input wire logic [3:0] c_en,
  input wire logic [3:0] c_lk,
  input wire logic [3:0] c_pc,
  input wire logic [3:0] c_ot,
  output logic [3:0] en,
  output logic [3:0] lk,
  output logic [3:0] ok,
  output logic [3:0] pc,
  output logic [3:0] ot
);
  // ability only with a link: negotiation needs one, so no free EEE
  always_ff @(posedge clk)
  begin
    en <= c_en;
    lk <= c_lk;
    ok <= c_lk;
    pc <= c_pc & ~c_ot;
    ot <= c_ot;
  end
endmodule : swpm_lp
`default_nettype wire

// ---- dv/tb_top.sv ----
/* bench: register tasks, queued read expectations, mode, energy,
   EEE and wake scenarios; assumes swpm_lp on the cable side */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import swpm_pkg::*;
  localparam int RLEN = 5;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, rd_q = 0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic [7:0] strap = '0;
  logic [3:0] req = '0, ce = '0, cl = '0, cp = '0, co = '0;
  logic [7:0] rb = '0;
  logic rv = 0, rf = 0;
  logic [47:0] ma = '0;
  wire logic [3:0] en, lu, ok, pc, ot, tl, tr, rl, rs;
  wire logic [DW-1:0] rdata;
  wire logic [7:0] scfg;
  wire logic [4:0] ppd;
  wire logic pll, mac, hif, phy, edet, lp, pev_n, irq_n;
  logic [DW-1:0] exq[$];
  int fails = 0, cmp_count = 0, cyc = 0, n;
  logic [31:0] seed = 32'h0a483914;
  always #20 clk = ~clk;
  swpm_lp lp_u (.clk(clk), .c_en(ce), .c_lk(cl), .c_pc(cp), .c_ot(co),
    .en(en), .lk(lu), .ok(ok), .pc(pc), .ot(ot));
  swpm_top #(.REFRESH_PERIOD_CYC(50), .REFRESH_LEN_CYC(RLEN), .LINK_PULSE_CYC(20))
  dut_u (.SYS_CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .STRAP_IN(strap), .ENERGY(en), .LINK_UP(lu),
    .LINK_EEE_OK(ok), .MAC_TX_LPI_REQ(req), .RX_PCODE(pc), .RX_OTHER(ot),
    .RX_BYTE(rb), .RX_BYTE_VALID(rv), .RX_FRAME_START(rf), .PLL_EN(pll),
    .MAC_EN(mac), .HOST_IF_EN(hif), .PHY_EN(phy), .RX_ENERGY_DET_EN(edet),
    .LINK_PULSE(lp), .PORT_POWER_DOWN(ppd), .TX_LPI(tl), .TX_REFRESH(tr),
    .MAC_RX_LPI(rl), .RX_CLK_STOP(rs), .STRAP_CFG(scfg), .POWER_EVENT_N(pev_n),
    .INTERRUPT_REQUEST_N(irq_n));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic cy(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cy
  task automatic wreg(logic [AW-1:0] a, logic [DW-1:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(logic [AW-1:0] a, logic [DW-1:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic tend(string s);
    $display("test %s done", s);
  endtask : tend
  // frame: six sync bytes, sixteen address copies; byte number bad is corrupted
  task automatic sfrm(logic [47:0] m, int bad);
    @(posedge clk);
    rf <= 1'b1;
    @(posedge clk);
    rf <= 1'b0;
    rv <= 1'b1;
    for (int i = 0; i < 102; i++)
    begin
      rb <= (i < 6) ? 8'hff : m[47 - 8 * ((i - 6) % 6) -: 8] ^ 8'(i == bad);
      @(posedge clk);
    end
    rv <= 1'b0;
  endtask : sfrm
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (rd_q)
      chk("rdata", exq.pop_front(), rdata);
    rd_q <= rd;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    strap = 8'(xs());
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    cy(2);
    chk("scfg", 16'(strap), 16'(scfg));
    rreg(REG_PWR_CTRL, 16'h0000);
    rreg(REG_EEE_EN, 16'h0000);
    rreg(REG_NOEN_TMO, NOEN_TMO_RST);
    rreg(5'h1f, 16'h0000);
    wreg(REG_PORT_PD, 16'h0011);
    cy(2);
    chk("ppd", 16'h0011, 16'(ppd));
    chk("full", 16'hf, 16'({pll, mac, hif, phy}));
    tend("reset");
    // energy mode is entered, then a write of the reserved code is refused and the mode holds
    wreg(REG_PWR_CTRL, 16'h0008);
    cy(2);
    chk("edet", 16'h1, 16'(edet));
    rreg(REG_STATUS, 16'h0001);
    wreg(REG_PWR_CTRL, 16'h0018);
    rreg(REG_PWR_CTRL, 16'h0008);
    wreg(REG_NOEN_TMO, 16'h0002);
    for (n = 0; n < 300 && pll !== 1'b0; n++) cy(1);
    chk("low", 16'h0, 16'({pll, mac, hif, phy}));
    for (n = 0; n < 30 && lp !== 1'b1; n++) cy(1);
    chk("pulse", 16'h1, 16'(lp));
    @(posedge clk);
    ce <= 4'h2;
    for (n = 0; n < 20 && pll !== 1'b1; n++) cy(1);
    chk("persist", 16'h1, 16'(n >= 5 && n <= 6));
    tend("energy");
    wreg(REG_PWR_CTRL, 16'h0010);
    cy(2);
    chk("sleep", 16'h1f0, {7'h0, ppd, pll, mac, hif, phy});
    rreg(REG_NOEN_TMO, 16'h0002);
    strap <= 8'(xs());
    wreg(REG_PWR_CTRL, 16'h0000);
    cy(3);
    rreg(REG_NOEN_TMO, NOEN_TMO_RST);
    rreg(REG_PORT_PD, 16'h0000);
    chk("scfg2", 16'(strap), 16'(scfg));
    tend("softpd");
    @(posedge clk);
    cl <= 4'h1;
    req <= 4'h1;
    cy(4);
    chk("tx_off", 16'h0, 16'(tl));
    wreg(REG_EEE_EN, 16'h000f);
    cy(2);
    chk("tx_lpi", 16'h1, 16'(tl));
    chk("rx_sep", 16'h0, 16'(rl));
    for (n = 0; n < 80 && tr[0] !== 1'b1; n++) cy(1);
    for (n = 0; n < 20 && tr[0] === 1'b1; n++) cy(1);
    chk("rf_len", 16'(RLEN), 16'(n));
    @(posedge clk);
    cp <= 4'h1;
    @(posedge clk);
    cp <= 4'h0;
    for (n = 0; n < 10 && rl[0] !== 1'b1; n++) cy(1);
    for (n = 0; n < 20 && rs[0] !== 1'b1; n++) cy(1);
    chk("rxstop", 16'h0009, 16'(n));
    @(posedge clk);
    co <= 4'h1;
    cy(3);
    chk("rx_wake", 16'h0, 16'({rl[0], rs[0]}));
    chk("tx_hold", 16'h1, 16'(tl));
    @(posedge clk);
    req <= 4'h0;
    co <= 4'h0;
    cy(3);
    chk("tx_wake", 16'h0, 16'(tl));
    tend("eee");
    wreg(REG_WAKE_CTRL, 16'h000a);
    @(posedge clk);
    cl <= 4'h5;
    for (n = 0; n < 10 && pev_n !== 1'b0; n++) cy(1);
    chk("pev_n", 16'h1, 16'({pev_n, irq_n}));
    rreg(REG_WAKE_STAT, 16'h0002);
    wreg(REG_WAKE_CTRL, 16'h001a);
    cy(3);
    chk("irq_n", 16'h0, 16'(irq_n));
    wreg(REG_WAKE_STAT, 16'h0002);
    cy(3);
    chk("clr", 16'h3, 16'({pev_n, irq_n}));
    tend("wake");
    ma = 48'({xs(), xs()});
    wreg(REG_MAC_HI, ma[47:32]);
    wreg(REG_MAC_MID, ma[31:16]);
    wreg(REG_MAC_LO, ma[15:0]);
    rreg(REG_MAC_MID, ma[31:16]);
    wreg(REG_WAKE_CTRL, 16'h000c);
    sfrm(ma, 50);
    cy(4);
    chk("wake_bad", 16'h1, 16'(pev_n));
    sfrm(ma, -1);
    cy(4);
    chk("wake_pkt", 16'h0, 16'(pev_n));
    rreg(REG_WAKE_STAT, 16'h0004);
    tend("wake_packet");
    wreg(REG_WAKE_STAT, 16'h0007);
    wreg(REG_EN_WAKE_TM, 16'h0002);
    wreg(REG_WAKE_CTRL, 16'h0009);
    @(posedge clk);
    ce <= 4'h0;
    cy(2);
    @(posedge clk);
    ce <= 4'h2;
    cy(45);
    chk("en_early", 16'h1, 16'(pev_n));
    cy(40);
    rreg(REG_WAKE_STAT, 16'h0001);
    tend("energy_wake");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
